/* rtl/pwm8_timer.sv */
// PWM timer: 8-bit counter with fast and phase-correct waveform generation
`timescale 1ns/10ps
// Summary of operation
// - Mode 3 counts up BOTTOM to MAX and restarts at BOTTOM.
// - Fast PWM: after MAX the counter clears on the next tick.
// - Fast PWM: overflow flag set whenever the counter reaches MAX.
// - Fast PWM action 2 clears at match, sets at BOTTOM; action 3 inverse.
// - Fast PWM BOTTOM action happens on the same tick as the wrap.
// - Compare BOTTOM gives one-tick spike; compare MAX gives constant level.
// - Fast PWM action 1 toggles on each match.
// - Fast PWM compare value is double buffered.
// - Fast PWM period is 256 ticks.
// - Prescaler divides by 1, 8, 32, 64, 128, 256 or 1024.
// - Mode 1 counts up to MAX then down to BOTTOM, repeatedly.
// - Phase-correct: MAX held one tick then counting turns down.
// - Phase-correct: overflow flag set when counter reaches BOTTOM.
// - Phase-correct action 2 clears on up match, sets on down; 3 inverse.
// - Phase-correct period is 510 ticks, eight-bit resolution.
// - Phase-correct compare BOTTOM holds low, MAX holds high, inverted opposite.
// - Output at MAX equals the up-counting match result, except with compare MAX.
// - Missed up-count match is still applied at MAX.
// - Tick is a clock enable on the reference clock.
// - MAX is 0xff, BOTTOM is 0x00.
// - Action 0 keeps compare output and releases the pin to port level.
module pwm8_timer
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rdata,
	// Port pin
	output pwm8_pkg::pin_t pin,
	// Flags and waveform state
	output logic overflow_flag,
	output logic compare_match_flag,
	output logic compare_out_a
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	pwm8_pkg::ctrl_t ctrl_r;
	logic [7:0] count_r, count_nxt;
	logic [7:0] cmp_buf_r;
	logic [7:0] cmp_act_r, cmp_act_nxt;
	logic down_r, down_nxt;
	logic out_r, out_nxt;
	logic ovf_r, match_r;
	logic [pwm8_pkg::presc_width-1:0] presc_r;
	logic block_r;
	logic [15:0] rdata_r;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire ctrl_wr = wr_en && (addr == pwm8_pkg::ctrl_addr);
	wire count_wr = wr_en && (addr == pwm8_pkg::count_addr);
	wire cmp_wr = wr_en && (addr == pwm8_pkg::compare_addr);
	wire stat_wr = wr_en && (addr == pwm8_pkg::status_addr);
	wire is_fast = ctrl_r.waveform_mode_sel == pwm8_pkg::mode_fast;
	wire is_phase = ctrl_r.waveform_mode_sel == pwm8_pkg::mode_phase;
	wire is_pwm = is_fast || is_phase;
	wire is_ctc = ctrl_r.waveform_mode_sel == pwm8_pkg::mode_ctc;
	pwm8_pkg::out_action_t act;
	assign act = ctrl_r.compare_out_action;

	// ------------------------------------------------------------
	// Prescaler and tick
	// ------------------------------------------------------------
	// Tap selected by the clock select field, zero means stopped
	function automatic logic tick_of(input logic [2:0] sel, input logic [9:0] p);
		case (sel)
			3'h1: tick_of = 1'b1;
			3'h2: tick_of = (p & pwm8_pkg::div8_mask) == pwm8_pkg::div8_mask;
			3'h3: tick_of = (p & pwm8_pkg::div32_mask) == pwm8_pkg::div32_mask;
			3'h4: tick_of = (p & pwm8_pkg::div64_mask) == pwm8_pkg::div64_mask;
			3'h5: tick_of = (p & pwm8_pkg::div128_mask) == pwm8_pkg::div128_mask;
			3'h6: tick_of = (p & pwm8_pkg::div256_mask) == pwm8_pkg::div256_mask;
			3'h7: tick_of = p == pwm8_pkg::div1024_mask;
			default: tick_of = 1'b0;
		endcase
	endfunction

	wire timer_tick = tick_of(ctrl_r.clk_sel, presc_r);

	// Free running prescaler
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			presc_r <= '0;
		else
			presc_r <= presc_r + 10'h001;
	end

	// ------------------------------------------------------------
	// Counter sequence
	// ------------------------------------------------------------
	// Top in non-CTC modes is MAX; CTC top is the compare value
	wire [7:0] top_val = is_ctc ? cmp_act_r : pwm8_pkg::count_max;
	wire at_top = count_r == top_val;
	wire at_bottom = count_r == pwm8_pkg::count_bottom;
	wire raw_match = (count_r == cmp_act_r) && !block_r;

	always_comb
	begin
		count_nxt = count_r;
		down_nxt = down_r;
		if (is_phase)
		begin
			// Turn down after one tick at MAX, up again at BOTTOM
			if (at_top)
				down_nxt = 1'b1;
			else if (at_bottom)
				down_nxt = 1'b0;
			if (down_nxt)
				count_nxt = count_r - 8'h01;
			else
				count_nxt = count_r + 8'h01;
		end
		else
		begin
			down_nxt = 1'b0;
			count_nxt = at_top ? pwm8_pkg::count_bottom : count_r + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Waveform output
	// ------------------------------------------------------------
	// Level that an up-counting match leaves for the current action
	wire up_level = (act == pwm8_pkg::act_set);
	wire cmp_is_max = cmp_act_r == pwm8_pkg::count_max;
	// A match at BOTTOM belongs to the up slope, so compare BOTTOM stays low
	wire match_down = down_r && !at_bottom;

	always_comb
	begin
		out_nxt = out_r;
		if (act == pwm8_pkg::act_off)
			out_nxt = out_r;
		else if (is_fast)
		begin
			if (act == pwm8_pkg::act_toggle)
			begin
				if (raw_match)
					out_nxt = !out_r;
			end
			else if (at_top)
				out_nxt = !up_level;
			else if (raw_match)
				out_nxt = up_level;
		end
		else if (is_phase && act != pwm8_pkg::act_toggle)
		begin
			if (at_top)
				out_nxt = cmp_is_max ? !up_level : up_level;
			else if (raw_match && !cmp_is_max)
				out_nxt = match_down ? !up_level : up_level;
		end
		else if (raw_match && !is_pwm)
		begin
			case (act)
				pwm8_pkg::act_toggle: out_nxt = !out_r;
				pwm8_pkg::act_clear: out_nxt = 1'b0;
				pwm8_pkg::act_set: out_nxt = 1'b1;
				default: out_nxt = out_r;
			endcase
		end
	end

	// Compare value: buffered in PWM modes, direct otherwise
	assign cmp_act_nxt = !is_pwm ? cmp_buf_r :
		((is_fast && at_top) || (is_phase && at_top)) ? cmp_buf_r : cmp_act_r;

	// Overflow at MAX in fast/normal, at BOTTOM in phase-correct
	wire ovf_evt = timer_tick && (is_phase ? (at_bottom && down_r) : at_top);
	wire match_evt = timer_tick && raw_match;

	// ------------------------------------------------------------
	// Sequential state
	// ------------------------------------------------------------
	// Counter, direction, output and compare registers
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			count_r <= pwm8_pkg::count_bottom;
			down_r <= 1'b0;
			out_r <= 1'b0;
			cmp_act_r <= pwm8_pkg::compare_reset;
		end
		else
		begin
			if (count_wr)
				count_r <= wdata[7:0];
			else if (timer_tick)
				count_r <= count_nxt;
			if (timer_tick)
				down_r <= down_nxt;
			if (timer_tick)
				out_r <= out_nxt;
			if (timer_tick || !is_pwm)
				cmp_act_r <= cmp_act_nxt;
		end
	end

	// A counter write blocks the match of the following tick
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			block_r <= 1'b0;
		else if (count_wr)
			block_r <= 1'b1;
		else if (timer_tick)
			block_r <= 1'b0;
	end

	// Control and buffered compare writes
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ctrl_r <= pwm8_pkg::ctrl_reset;
			cmp_buf_r <= pwm8_pkg::compare_reset;
		end
		else
		begin
			if (ctrl_wr)
				ctrl_r <= wdata[8:0];
			if (cmp_wr)
				cmp_buf_r <= wdata[7:0];
		end
	end

	// Sticky flags, set wins over a write-one clear
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ovf_r <= 1'b0;
			match_r <= 1'b0;
		end
		else
		begin
			ovf_r <= ovf_evt || (ovf_r && !(stat_wr && wdata[pwm8_pkg::ovf_bit]));
			match_r <= match_evt || (match_r && !(stat_wr && wdata[pwm8_pkg::match_bit]));
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	wire [15:0] stat_word = {12'h000, out_r, down_r, match_r, ovf_r};
	wire [15:0] rd_mux =
		(addr == pwm8_pkg::ctrl_addr) ? {7'h00, ctrl_r} :
		(addr == pwm8_pkg::count_addr) ? {8'h00, count_r} :
		(addr == pwm8_pkg::compare_addr) ? {8'h00, cmp_buf_r} :
		(addr == pwm8_pkg::status_addr) ? stat_word :
		(addr == pwm8_pkg::active_cmp_addr) ? {8'h00, cmp_act_r} : 16'h0000;

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			rdata_r <= 16'h0000;
		else if (rd_en)
			rdata_r <= rd_mux;
		else
			rdata_r <= 16'h0000;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Pin takes compare output when any action is selected
	assign pin.out = (act != pwm8_pkg::act_off) ? out_r : ctrl_r.port_level;
	assign pin.oe = ctrl_r.pin_dir;
	assign rdata = rdata_r;
	assign overflow_flag = ovf_r;
	assign compare_match_flag = match_r;
	assign compare_out_a = out_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence fast_wrap_s;
		timer_tick && is_fast && count_r == 8'hff && !count_wr;
	endsequence

	fast_wrap_a: assert property (@(posedge ref_clk) disable iff (reset)
		fast_wrap_s |=> count_r == 8'h00)
		else $error("fast mode did not wrap to zero");
	fast_ovf_a: assert property (@(posedge ref_clk) disable iff (reset)
		fast_wrap_s |=> overflow_flag)
		else $error("overflow not set at max");
	fast_bottom_a: assert property (@(posedge ref_clk) disable iff (reset)
		fast_wrap_s and (act == pwm8_pkg::act_clear && !$changed(ctrl_r)) |=> compare_out_a)
		else $error("bottom set missing");
	fast_toggle_a: assert property (@(posedge ref_clk) disable iff (reset)
		timer_tick && is_fast && act == pwm8_pkg::act_toggle && raw_match
		|=> compare_out_a != $past(compare_out_a))
		else $error("toggle missing");
	phase_turn_a: assert property (@(posedge ref_clk) disable iff (reset)
		timer_tick && is_phase && count_r == 8'hff && !count_wr |=> count_r == 8'hfe && down_r)
		else $error("phase turn wrong");
	phase_ovf_a: assert property (@(posedge ref_clk) disable iff (reset)
		timer_tick && is_phase && count_r == 8'h00 && down_r |=> overflow_flag)
		else $error("phase overflow missing");
	buf_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
		is_pwm && !at_top && !$changed(ctrl_r) |=> $stable(cmp_act_r))
		else $error("compare changed mid period");
	pin_src_a: assert property (@(posedge ref_clk) disable iff (reset)
		act != pwm8_pkg::act_off |-> pin.out == compare_out_a)
		else $error("pin not driven by compare output");
	ovf_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
		overflow_flag && !stat_wr |=> overflow_flag)
		else $error("overflow lost");

	// Ticks since the last fast-mode wrap, used by the period check
	logic [8:0] gap_r;
	logic gap_ok_r;

	always_ff @(posedge ref_clk)
	begin
		if (reset || !is_fast || count_wr)
		begin
			gap_r <= 9'h000;
			gap_ok_r <= 1'b0;
		end
		else if (timer_tick && at_top)
		begin
			gap_r <= 9'h001;
			gap_ok_r <= 1'b1;
		end
		else if (timer_tick)
			gap_r <= gap_r + 9'h001;
	end

	fast_period_a: assert property (@(posedge ref_clk) disable iff (reset)
		fast_wrap_s and gap_ok_r |-> gap_r == {1'b0, pwm8_pkg::count_max} + 9'h001)
		else $error("fast period not 256 ticks");

	// Phase-correct steps: a match on either slope, and the tick at MAX
	sequence phase_match_s;
		timer_tick && is_phase && raw_match && !cmp_is_max && act == pwm8_pkg::act_clear;
	endsequence
	sequence phase_top_s;
		timer_tick && is_phase && at_top && act == pwm8_pkg::act_clear;
	endsequence

	phase_up_a: assert property (@(posedge ref_clk) disable iff (reset)
		phase_match_s and !match_down |=> !compare_out_a)
		else $error("up-slope match did not clear the output");
	phase_down_a: assert property (@(posedge ref_clk) disable iff (reset)
		phase_match_s and match_down |=> compare_out_a)
		else $error("down-slope match did not set the output");
	phase_top_a: assert property (@(posedge ref_clk) disable iff (reset)
		phase_top_s and !cmp_is_max |=> !compare_out_a)
		else $error("output at max differs from up-slope result");
	phase_max_a: assert property (@(posedge ref_clk) disable iff (reset)
		phase_top_s and cmp_is_max |=> compare_out_a)
		else $error("compare max did not hold the output high");
	buf_load_a: assert property (@(posedge ref_clk) disable iff (reset)
		timer_tick && is_pwm && at_top |=> cmp_act_r == $past(cmp_buf_r))
		else $error("buffered compare not loaded at top");
	stop_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
		ctrl_r.clk_sel == 3'h0 && !count_wr |=> $stable(count_r))
		else $error("stopped counter moved");
endmodule // pwm8_timer

/* rtl/pwm8_pkg.sv */
// Package: register map, field layout, modes and reset values for the 8-bit PWM timer
package pwm8_pkg;
	// Register offsets
	localparam logic [3:0] ctrl_addr = 4'h0;
	localparam logic [3:0] count_addr = 4'h1;
	localparam logic [3:0] compare_addr = 4'h2;
	localparam logic [3:0] status_addr = 4'h3;
	localparam logic [3:0] active_cmp_addr = 4'h4;
	// Control field positions
	localparam int clk_sel_lsb = 0;
	localparam int mode_lsb = 3;
	localparam int action_lsb = 5;
	localparam int pin_dir_bit = 7;
	localparam int port_level_bit = 8;
	// Status field positions (overflow and match bits write one to clear)
	localparam int ovf_bit = 0;
	localparam int match_bit = 1;
	localparam int dir_bit = 2;
	localparam int out_bit = 3;
	// Counter limits
	localparam logic [7:0] count_bottom = 8'h00;
	localparam logic [7:0] count_max = 8'hff;
	// Reset values
	localparam logic [8:0] ctrl_reset = 9'h000;
	localparam logic [7:0] compare_reset = 8'h00;
	// Prescaler width and tap points (divide minus one)
	localparam int presc_width = 10;
	localparam logic [9:0] div8_mask = 10'h007;
	localparam logic [9:0] div32_mask = 10'h01f;
	localparam logic [9:0] div64_mask = 10'h03f;
	localparam logic [9:0] div128_mask = 10'h07f;
	localparam logic [9:0] div256_mask = 10'h0ff;
	localparam logic [9:0] div1024_mask = 10'h3ff;
	// Waveform modes
	typedef enum logic [1:0] {
		mode_normal = 2'h0,
		mode_phase = 2'h1,
		mode_ctc = 2'h2,
		mode_fast = 2'h3
	} wave_mode_t;
	// Output actions
	typedef enum logic [1:0] {
		act_off = 2'h0,
		act_toggle = 2'h1,
		act_clear = 2'h2,
		act_set = 2'h3
	} out_action_t;
	// Control register image
	typedef struct packed {
		logic port_level;
		logic pin_dir;
		out_action_t compare_out_action;
		wave_mode_t waveform_mode_sel;
		logic [2:0] clk_sel;
	} ctrl_t;
	// Pin drive bundle
	typedef struct packed {
		logic out;
		logic oe;
	} pin_t;
endpackage

/* test/pin_load.sv */
// Pin load model: pad level seen by the external filter
`timescale 1ns/10ps
module pin_load
(
	// Pin drive from the timer
	input wire pwm8_pkg::pin_t pin,
	// Level at the pad
	output logic pad
);
	// Pull-down holds the pad low while the driver is off
	assign pad = pin.oe ? pin.out : 1'b0;
endmodule // pin_load

/* test/timer8_pwm_waveform_modes_test.sv */
// Testbench for the PWM timer: waveforms, prescaler, flags, registers
`timescale 1ns/10ps
module timer8_pwm_waveform_modes_test;
	// ---------------------------------------
	// Harness
	// ---------------------------------------
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [15:0] rdata;
	pwm8_pkg::pin_t pin;
	logic ovf, match, cout;
	logic pad;
	logic [15:0] v;
	logic [15:0] c0;
	logic [1:0] rm, ra;
	logic [7:0] rc;
	logic [7:0] last_cmp = 8'h00;
	int fails = 0;
	int comparisons = 0;
	int seed = 32'h709e7c9a;
	int divs [7] = '{1, 8, 32, 64, 128, 256, 1024};

	// Clock at 125 MHz
	always #4 ref_clk = ~ref_clk;

	// Design and pad load
	pwm8_timer dut_u (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin(pin), .overflow_flag(ovf),
		.compare_match_flag(match), .compare_out_a(cout));
	pin_load load_u (.pin(pin), .pad(pad));

	// Verdict and end of run
	task automatic tally_and_finish();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Register value comparison
	task automatic check_reg(string name, logic [15:0] exp, logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Waveform high-time comparison
	task automatic check_duty(string name, int exp, int got);
		comparisons++;
		if (got != exp)
		begin
			fails++;
			$display("unexpected %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(logic [3:0] a, logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	// Read strobe, data taken in the following cycle
	task automatic rd(logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask

	// Control word from its fields
	function automatic logic [15:0] cw(logic [2:0] cs, logic [1:0] m, logic [1:0] a, logic dir,
		logic lvl);
		return {7'h00, lvl, dir, a, m, cs};
	endfunction

	// Window length for one output cycle
	function automatic int period(logic [1:0] m, logic [1:0] a);
		return (a == 2'h1) ? 512 : ((m == 2'h3) ? 256 : 510);
	endfunction

	// Expected pad high cycles in one window
	function automatic int exp_high(logic [1:0] m, logic [1:0] a, logic [7:0] c);
		int hi;
		if (a == 2'h1)
			return 256;
		if (m == 2'h3)
			hi = (c == 8'hff) ? 256 : int'(c) + 1;
		else
			hi = 2 * int'(c);
		return (a == 2'h3) ? period(m, a) - hi : hi;
	endfunction

	// Configure, let the buffered compare land, count high cycles at the pad
	task automatic duty(logic [1:0] m, logic [1:0] a, logic [7:0] c);
		int hi;
		int hc;
		hi = 0;
		hc = 0;
		wr(pwm8_pkg::ctrl_addr, cw(3'h1, m, a, 1'b1, 1'b0));
		wr(pwm8_pkg::compare_addr, {8'h00, c});
		last_cmp = c;
		repeat (1100) @(posedge ref_clk);
		repeat (period(m, a))
		begin
			@(posedge ref_clk);
			#1;
			if (pad === 1'b1)
				hi++;
			if (cout === 1'b1)
				hc++;
		end
		check_duty("pad high cycles", exp_high(m, a, c), hi);
		check_duty("compare_out_a high cycles", exp_high(m, a, c), hc);
	endtask

	// Hang guard
	initial
	begin
		#(8 * 80000);
		fails++;
		tally_and_finish();
	end

	// ---------------------------------------
	// Scenarios
	// ---------------------------------------
	initial
	begin
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		// Reset values and an unmapped place
		for (int i = 0; i < 6; i++)
		begin
			rd((i < 5) ? 4'(i) : 4'hf, v);
			check_reg("reset read", 16'h0000, v);
		end
		wr(4'hf, 16'hffff);
		rd(pwm8_pkg::ctrl_addr, v);
		check_reg("ctrl after unmapped write", 16'h0000, v);
		// Port level passes through with action off, pull-down when not driven
		wr(pwm8_pkg::ctrl_addr, cw(3'h0, 2'h0, 2'h0, 1'b1, 1'b1));
		#1;
		check_reg("pad port level", 16'h0001, {15'h0, pad});
		wr(pwm8_pkg::ctrl_addr, cw(3'h0, 2'h0, 2'h0, 1'b0, 1'b1));
		#1;
		check_reg("pad undriven", 16'h0004, {13'h0, pin.out, pin.oe, pad});
		// Compare buffered while stopped, loaded at top once running
		wr(pwm8_pkg::ctrl_addr, cw(3'h0, 2'h3, 2'h2, 1'b1, 1'b0));
		wr(pwm8_pkg::compare_addr, 16'h005a);
		rd(pwm8_pkg::active_cmp_addr, v);
		check_reg("active compare held", {8'h00, last_cmp}, v);
		rd(pwm8_pkg::compare_addr, v);
		check_reg("compare buffer", 16'h005a, v);
		wr(pwm8_pkg::ctrl_addr, cw(3'h1, 2'h3, 2'h2, 1'b1, 1'b0));
		repeat (300) @(posedge ref_clk);
		rd(pwm8_pkg::active_cmp_addr, v);
		check_reg("active compare loaded", 16'h005a, v);
		last_cmp = 8'h5a;
		// Overflow flag in both PWM modes, write one clears
		for (int m = 1; m < 4; m += 2)
		begin
			wr(pwm8_pkg::ctrl_addr, cw(3'h0, 2'(m), 2'h2, 1'b1, 1'b0));
			wr(pwm8_pkg::status_addr, 16'h0003);
			rd(pwm8_pkg::status_addr, v);
			check_reg("flags cleared", 16'h0000, v & 16'h0003);
			wr(pwm8_pkg::ctrl_addr, cw(3'h1, 2'(m), 2'h2, 1'b1, 1'b0));
			repeat (520) @(posedge ref_clk);
			check_reg("overflow_flag", 16'h0001, {15'h0, ovf});
			check_reg("compare_match_flag", 16'h0001, {15'h0, match});
		end
		// Extreme compare values, both polarities, both modes
		for (int k = 0; k < 8; k++)
			duty(k[2] ? 2'h3 : 2'h1, k[1] ? 2'h3 : 2'h2, k[0] ? 8'hff : 8'h00);
		// Toggle at compare zero gives half duty
		duty(2'h3, 2'h1, 8'h00);
		// Random compare values
		repeat (6)
		begin
			rm = ($random(seed) & 1) ? 2'h3 : 2'h1;
			ra = 2'h2 + 2'($random(seed) & 1);
			rc = 8'($random(seed));
			duty(rm, ra, rc);
		end
		// Prescaler: four divide periods give four counts
		for (int i = 0; i < 7; i++)
		begin
			wr(pwm8_pkg::ctrl_addr, cw(3'(i + 1), 2'h3, 2'h0, 1'b0, 1'b0));
			rd(pwm8_pkg::count_addr, c0);
			repeat (4 * divs[i] - 2) @(posedge ref_clk);
			rd(pwm8_pkg::count_addr, v);
			check_reg("count advance", 16'h0004, (v - c0) & 16'h00ff);
		end
		// Counter load while stopped, held without ticks, read data released after one cycle
		wr(pwm8_pkg::ctrl_addr, cw(3'h0, 2'h3, 2'h0, 1'b0, 1'b0));
		wr(pwm8_pkg::count_addr, 16'h0037);
		repeat (20) @(posedge ref_clk);
		rd(pwm8_pkg::count_addr, v);
		check_reg("count loaded", 16'h0037, v);
		@(posedge ref_clk);
		#1;
		check_reg("read data released", 16'h0000, rdata);
		tally_and_finish();
	end
endmodule // timer8_pwm_waveform_modes_test
